// ---- logic/om_pkg.sv ----
package om_pkg;

	// Clock and measurement gate
	localparam int CLK_HZ       = 40_000_000;
	localparam int GATE_MS      = 100;
	localparam int GATE_CYC_DEF = CLK_HZ / 1000 * GATE_MS;

	// Register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_RES1   = 8'h04;
	localparam logic [7:0] A_RES2   = 8'h08;
	localparam logic [7:0] A_PITCH  = 8'h0C;
	localparam logic [7:0] A_GEARHY = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_UPPER  = 8'h18;
	localparam logic [7:0] A_LOWER  = 8'h1C;
	localparam logic [7:0] A_THR0   = 8'h20;
	localparam int         THR_N    = 8;

	// Field positions
	localparam int GEAR_LSB = 0;
	localparam int HYST_LSB = 8;
	localparam int ST_OK    = 16;
	localparam int ST_DIR   = 17;
	localparam int ST_FLT   = 18;

	// Reset values
	localparam logic [15:0] RES_RST  = 16'h0001;
	localparam logic [15:0] THR_RST  = 16'hFFFF;
	localparam logic [7:0]  GEAR_RST = 8'h01;
	localparam logic [6:0]  HYST_RST = 7'h00;

	// Conversion constants
	localparam logic [47:0] SEC_PER_MIN = 48'h0000_0000_003C;
	localparam logic [47:0] MS_PER_SEC  = 48'h0000_0000_03E8;
	localparam logic [47:0] PCT_FULL    = 48'h0000_0000_0064;
	localparam logic [47:0] GATE_MS_W   = 48'(GATE_MS);
	localparam int          DIV_STEPS   = 48;

	// Plausibility limits
	localparam logic [15:0] MISS_MIN = 16'h0004;
	localparam logic [15:0] DUTY_TOL = 16'h0001;
	localparam logic [47:0] CONG_ABS = 48'h0000_0000_0002;
	localparam int          CONG_SH  = 3;

	typedef enum logic [2:0] {M_ENC, M_PROX, M_ENC_PROX, M_PROX_PROX, M_ENC_ENC} om_meas_t;
	typedef enum logic [3:0] {P_NONE, P_PNP3_NC, P_PNP3_NO, P_NPN3_NO, P_NPN3_NC,
		P_PNP4_NCNO, P_NPN4_NCNO, P_PP4_NCNC, P_PP4_NONO} om_prox_type_t;
	typedef enum logic [1:0] {D_BIDIR, D_CW, D_CCW} om_dir_mode_t;
	typedef enum logic [1:0] {S_IDLE, S_UPPER, S_LOWER} om_div_state_t;

	typedef struct packed {
		logic [2:0]    thr_num_m1;
		logic          analog_dis;
		logic          err_en;
		logic          dir_en;
		om_dir_mode_t  dir_mode;
		om_prox_type_t prox_type;
		om_meas_t      meas;
		logic          sens_lin;
		logic          axis_lin;
	} om_ctrl_t;

	typedef struct packed {
		logic a;
		logic b;
	} om_enc_t;

	typedef struct packed {
		logic w1;
		logic w2;
	} om_prox_t;

endpackage

// ---- logic/om_overspeed_monitor.sv ----
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module om_overspeed_monitor #(
	parameter int GATE_CYC = om_pkg::GATE_CYC_DEF
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Wishbone slave
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic                  wb_we_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Sensors
	input  wire om_pkg::om_enc_t [1:0]  enc_i,
	input  wire om_pkg::om_prox_t [1:0] prox_i,
	input  wire logic [1:0]            enc_line_ok_i,
	input  wire logic [1:0]            enc_pwr_ok_i,
	input  wire logic [1:0]            sincos_ok_i,
	// Threshold select
	input  wire logic                  threshold_select_bit0_i,
	input  wire logic                  threshold_select_bit1_i,
	input  wire logic                  threshold_select_bit2_i,
	// Results
	output logic                       speed_ok_o,
	output logic                       dir_o,
	output logic                       fault_o
);
	import om_pkg::*;

	om_ctrl_t      ctrl_r;
	logic [15:0]   res1_r;
	logic [15:0]   res2_r;
	logic [15:0]   pitch_r;
	logic [7:0]    gear_r;
	logic [6:0]    hyst_r;
	logic [15:0]   thr_r [THR_N];
	logic [31:0]   upper_r;
	logic [31:0]   lower_r;
	logic [15:0]   c1_r;
	logic [31:0]   gcnt_r;
	logic          gate_end;
	logic [2:0]    sel_m_r;
	logic [2:0]    sel_s_r;
	logic [2:0]    sel_r;
	logic          req;
	logic [31:0]   rdata;
	logic [31:0]   wmask;
	logic [5:0]    widx;
	logic          wr;
	logic          thr_hit;
	logic [2:0]    tidx;

	// Wishbone slave, one wait state
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign widx = wb_adr_i[7:2];
	// Writes commit on the edge that sees ack high
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign tidx = 3'(widx - A_THR0[7:2]);
	assign thr_hit = (wb_adr_i >= A_THR0) && ((widx - A_THR0[7:2]) < 6'(THR_N));
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
		return (old & ~m) | (d & m);
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (req)
			wb_dat_o <= rdata;
	end

	always_comb
	begin
		rdata = 32'h0000_0000;
		if (thr_hit)
			rdata = {16'h0000, thr_r[tidx]};
		else
			case (wb_adr_i)
				A_CTRL:   rdata = 32'(ctrl_r);
				A_RES1:   rdata = {16'h0000, res1_r};
				A_RES2:   rdata = {16'h0000, res2_r};
				A_PITCH:  rdata = {16'h0000, pitch_r};
				A_GEARHY: rdata = {17'h0_0000, hyst_r, gear_r};
				A_STATUS: rdata = {13'h0000, fault_o, dir_o, speed_ok_o, c1_r};
				A_UPPER:  rdata = upper_r;
				A_LOWER:  rdata = lower_r;
				default:  rdata = 32'h0000_0000;
			endcase
	end

	// Configuration registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r  <= '0;
			res1_r  <= RES_RST;
			res2_r  <= RES_RST;
			pitch_r <= RES_RST;
			gear_r  <= GEAR_RST;
			hyst_r  <= HYST_RST;
			for (int i = 0; i < THR_N; i++)
				thr_r[i] <= THR_RST;
		end
		else if (wr)
		begin
			if (thr_hit)
				thr_r[tidx] <= 16'(merge(32'(thr_r[tidx]), wmask, wb_dat_i));
			else
				case (wb_adr_i)
					A_CTRL:   ctrl_r  <= om_ctrl_t'(17'(merge(32'(ctrl_r), wmask, wb_dat_i)));
					A_RES1:   res1_r  <= 16'(merge(32'(res1_r), wmask, wb_dat_i));
					A_RES2:   res2_r  <= 16'(merge(32'(res2_r), wmask, wb_dat_i));
					A_PITCH:  pitch_r <= 16'(merge(32'(pitch_r), wmask, wb_dat_i));
					A_GEARHY:
					begin
						gear_r <= wb_sel_i[0] ? wb_dat_i[GEAR_LSB +: 8] : gear_r;
						hyst_r <= wb_sel_i[1] ? wb_dat_i[HYST_LSB +: 7] : hyst_r;
					end
					default: ;
				endcase
		end
	end

	// Measurement gate
	assign gate_end = (gcnt_r == 32'(GATE_CYC - 1));

	always_ff @(posedge clk_i)
	begin
		if (rst_i || gate_end)
			gcnt_r <= 32'h0000_0000;
		else
			gcnt_r <= gcnt_r + 32'h0000_0001;
	end

	// Select synchroniser, sampled at gate end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sel_m_r <= 3'h0;
			sel_s_r <= 3'h0;
			sel_r   <= 3'h0;
		end
		else
		begin
			sel_m_r <= {threshold_select_bit2_i, threshold_select_bit1_i, threshold_select_bit0_i};
			sel_s_r <= sel_m_r;
			if (gate_end)
				sel_r <= (sel_s_r > ctrl_r.thr_num_m1) ? ctrl_r.thr_num_m1 : sel_s_r;
		end
	end

	// Sensor front ends
	logic [1:0]  enc_used;
	logic [1:0]  prox_used;
	om_enc_t     ep_r [2];
	logic [15:0] ra_r [2];
	logic [15:0] rb_r [2];
	logic [1:0]  phase_r;
	logic [1:0]  ep_flt;
	om_prox_t    pp_r [2];
	logic [15:0] pr_r [2];
	logic [1:0]  pmis_r;
	logic [1:0]  pulse;
	logic        inv;
	logic        dir_ccw_r;

	assign enc_used  = {ctrl_r.meas == M_ENC_ENC,
		ctrl_r.meas inside {M_ENC, M_ENC_PROX, M_ENC_ENC}};
	assign prox_used = {ctrl_r.meas == M_PROX_PROX, ctrl_r.meas inside {M_PROX, M_ENC_PROX, M_PROX_PROX}};
	assign inv = ctrl_r.prox_type inside {P_PNP3_NC, P_NPN3_NO, P_NPN4_NCNO, P_PP4_NCNC};

	for (genvar k = 0; k < 2; k++)
	begin : g_sens
		logic ar;
		logic br;
		logic pr;
		assign ar = enc_i[k].a & ~ep_r[k].a;
		assign br = enc_i[k].b & ~ep_r[k].b;
		assign pulse[k] = prox_i[k].w1 ^ inv;
		assign pr = pulse[k] & ~(pp_r[k].w1 ^ inv);
		assign ep_flt[k] = enc_used[k] & (~enc_line_ok_i[k] | ~enc_pwr_ok_i[k]
			| (~ctrl_r.analog_dis & ~sincos_ok_i[k]));

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				ep_r[k] <= '0;
				pp_r[k] <= '0;
			end
			else
			begin
				ep_r[k] <= enc_i[k];
				pp_r[k] <= prox_i[k];
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i || gate_end)
			begin
				ra_r[k] <= 16'h0000;
				rb_r[k] <= 16'h0000;
				pr_r[k] <= 16'h0000;
			end
			else
			begin
				ra_r[k] <= ra_r[k] + 16'(ar && ra_r[k] != 16'hFFFF);
				rb_r[k] <= rb_r[k] + 16'(br && rb_r[k] != 16'hFFFF);
				pr_r[k] <= pr_r[k] + 16'(pr && pr_r[k] != 16'hFFFF);
			end
		end

		// Both phases switching together breaks quadrature
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				phase_r[k] <= 1'b0;
			else if ((enc_i[k].a ^ ep_r[k].a) && (enc_i[k].b ^ ep_r[k].b))
				phase_r[k] <= 1'b1;
			else if (gate_end)
				phase_r[k] <= 1'b0;
		end

		// Four-wire pair must stay complementary beyond one cycle of skew
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				pmis_r[k] <= 1'b0;
			else
				pmis_r[k] <= (prox_i[k].w1 == prox_i[k].w2) && (pp_r[k].w1 == pp_r[k].w2)
					&& ctrl_r.prox_type >= P_PNP4_NCNO;
		end
	end

	// Direction from first encoder
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dir_ccw_r <= 1'b0;
		else if (enc_i[0].a & ~ep_r[0].a)
			dir_ccw_r <= enc_i[0].b;
	end

	// Primary and secondary counts
	logic [15:0] c1;
	logic [15:0] c2;
	logic        two;

	assign c1 = enc_used[0] ? ra_r[0] : pr_r[0];
	assign c2 = (ctrl_r.meas == M_ENC_ENC) ? ra_r[1] : (ctrl_r.meas == M_PROX_PROX) ? pr_r[1] : pr_r[0];
	assign two = ctrl_r.meas inside {M_ENC_PROX, M_PROX_PROX, M_ENC_ENC};

	// Cross-check with gear ratio and second resolution
	logic [47:0] lhs;
	logic [47:0] rhs;
	logic [47:0] dif;
	logic        cong_err;
	logic        miss_err;
	logic        duty_err;

	assign lhs = 48'(c2) * 48'(res1_r);
	assign rhs = 48'(c1) * 48'(gear_r) * 48'(res2_r);
	assign dif = (lhs > rhs) ? lhs - rhs : rhs - lhs;
	assign cong_err = two && dif > ((lhs > rhs ? lhs : rhs) >> CONG_SH) + CONG_ABS * 48'(res1_r);
	assign miss_err = two && ((c1 >= MISS_MIN && c2 == 16'h0000) || (c2 >= MISS_MIN && c1 == 16'h0000));
	always_comb
	begin
		duty_err = 1'b0;
		for (int k = 0; k < 2; k++)
			if (enc_used[k] && (ra_r[k] > rb_r[k] + DUTY_TOL || rb_r[k] > ra_r[k] + DUTY_TOL))
				duty_err = 1'b1;
	end

	// Fault reporting
	logic gflt_r;
	logic lvl;

	assign lvl = |ep_flt | |(prox_used & pmis_r) | (|prox_used && ctrl_r.prox_type == P_NONE);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gflt_r <= 1'b0;
		else if (gate_end)
			gflt_r <= |(phase_r & enc_used) | duty_err | cong_err | miss_err;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_o <= 1'b0;
		else
			fault_o <= ctrl_r.err_en & (lvl | gflt_r);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dir_o <= 1'b0;
		else
			dir_o <= ctrl_r.dir_en & enc_used[0] & dir_ccw_r;
	end

	// Threshold conversion by sequential divider
	om_div_state_t st_r;
	logic [47:0]   num_r;
	logic [31:0]   den_r;
	logic [32:0]   rem_r;
	logic [5:0]    step_r;
	logic [32:0]   rtry;
	logic [31:0]   quo;
	logic          qbit;
	logic [47:0]   num0;
	logic [31:0]   den0;

	assign rtry = {rem_r[31:0], num_r[47]};
	assign qbit = rtry >= {1'b0, den_r};
	// Final quotient, saturated beyond 32 bits
	assign quo = |num_r[46:31] ? 32'hFFFF_FFFF : {num_r[30:0], qbit};

	always_comb
	begin
		num0 = 48'(thr_r[sel_r]) * 48'(res1_r) * GATE_MS_W;
		den0 = 32'(SEC_PER_MIN * MS_PER_SEC);
		if (ctrl_r.axis_lin && ctrl_r.sens_lin)
		begin
			num0 = 48'(thr_r[sel_r]) * GATE_MS_W;
			den0 = 32'(res1_r);
		end
		else if (ctrl_r.axis_lin)
			den0 = 32'(SEC_PER_MIN * 48'(pitch_r));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r    <= S_IDLE;
			num_r   <= '0;
			den_r   <= '0;
			rem_r   <= '0;
			step_r  <= '0;
			upper_r <= 32'hFFFF_FFFF;
			lower_r <= 32'hFFFF_FFFF;
		end
		else
			case (st_r)
				S_IDLE:
					if (gate_end)
					begin
						num_r  <= num0;
						den_r  <= den0;
						rem_r  <= '0;
						step_r <= '0;
						st_r   <= S_UPPER;
					end
				S_UPPER, S_LOWER:
				begin
					if (rtry >= {1'b0, den_r})
					begin
						rem_r <= rtry - {1'b0, den_r};
						num_r <= {num_r[46:0], 1'b1};
					end
					else
					begin
						rem_r <= rtry;
						num_r <= {num_r[46:0], 1'b0};
					end
					step_r <= step_r + 6'h01;
					if (step_r == 6'(DIV_STEPS - 1) && st_r == S_UPPER)
					begin
						upper_r <= quo;
						num_r   <= 48'(quo) * (PCT_FULL - 48'(hyst_r));
						den_r   <= 32'(PCT_FULL);
						rem_r   <= '0;
						step_r  <= '0;
						st_r    <= S_LOWER;
					end
					else if (step_r == 6'(DIV_STEPS - 1))
					begin
						lower_r <= quo;
						st_r    <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
	end

	// Overspeed decision with hysteresis
	logic dir_match;

	always_comb
	begin
		case (ctrl_r.dir_mode)
			D_CW:    dir_match = ~enc_used[0] | ~dir_ccw_r;
			D_CCW:   dir_match = ~enc_used[0] | dir_ccw_r;
			default: dir_match = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			speed_ok_o <= 1'b1;
			c1_r       <= 16'h0000;
		end
		else if (gate_end)
		begin
			c1_r <= c1;
			if (speed_ok_o && dir_match && 32'(c1) > upper_r)
				speed_ok_o <= 1'b0;
			else if (!speed_ok_o && (!dir_match || 32'(c1) < lower_r))
				speed_ok_o <= 1'b1;
		end
	end

endmodule

// ---- bench/om_enc_model.sv ----
`timescale 1ns/10ps
module om_enc_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Motion control
	input  wire logic       run_i,
	input  wire logic       ccw_i,
	input  wire logic [7:0] step_i,
	// Phases
	output om_pkg::om_enc_t enc_o
);
	import om_pkg::*;

	logic [7:0] cnt_r;
	logic [1:0] ph_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_i || cnt_r >= step_i - 8'h01)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end

	// Forward walk makes A rise with B high: counterclockwise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ph_r <= 2'b00;
		else if (run_i && cnt_r >= step_i - 8'h01)
			ph_r <= ccw_i ? ph_r + 2'b01 : ph_r - 2'b01;
	end

	assign enc_o = {ph_r[1], ph_r[1] ^ ph_r[0]};
endmodule

// ---- bench/om_chk.sv ----
`timescale 1ns/10ps
module om_chk #(
	parameter int GATE_CYC = om_pkg::GATE_CYC_DEF
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Bus handshake
	input  wire logic wb_cyc_i,
	input  wire logic wb_stb_i,
	input  wire logic wb_ack_o,
	// Encoder phases
	input  wire om_pkg::om_enc_t [1:0] enc_i,
	// Results
	input  wire logic speed_ok_o,
	input  wire logic dir_o,
	input  wire logic fault_o
);
	logic [31:0] gcnt_r;

	// Mirrors the measurement gate
	always_ff @(posedge clk_i)
	begin
		if (rst_i || gcnt_r == GATE_CYC - 1)
			gcnt_r <= '0;
		else
			gcnt_r <= gcnt_r + 1;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_bus_answer: assert property (s_req |=> s_ans)
		else $error("bus request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack while idle");
	a_rst_values: assert property (disable iff (1'b0) rst_i |=> speed_ok_o && !dir_o && !fault_o && !wb_ack_o)
		else $error("outputs wrong after reset");
	a_ok_gate_end: assert property (!$stable(speed_ok_o) |-> $past(gcnt_r) == GATE_CYC - 1)
		else $error("speed result changed off gate end");
	a_dir_cw_low: assert property ($rose(enc_i[0].a) && !enc_i[0].b |-> ##2 !dir_o)
		else $error("direction high after clockwise edge");
	a_ok_hold: assert property ($fell(speed_ok_o) |=> $stable(speed_ok_o) [*8])
		else $error("overspeed result not held");
endmodule

bind om_overspeed_monitor om_chk #(.GATE_CYC(GATE_CYC)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .enc_i, .speed_ok_o, .dir_o, .fault_o);

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	import om_pkg::*;

	localparam int GATE = 400;
	localparam int SETTLE = 10;

	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_we;
	logic        wb_ack;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic [31:0] rd_q;
	logic [2:0]  sel;
	logic [1:0]  line_ok;
	logic [1:0]  pwr_ok;
	logic [1:0]  sc_ok;
	logic        run;
	logic        ccw;
	logic [7:0]  step;
	logic        ok;
	logic        dir;
	logic        flt;
	om_enc_t     enc;
	int          err_total;
	int          check_count;

	om_enc_model i_enc (.clk_i, .rst_i, .run_i(run), .ccw_i(ccw), .step_i(step), .enc_o(enc));

	om_overspeed_monitor #(.GATE_CYC(GATE)) i_dut (.clk_i, .rst_i, .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
		.wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .enc_i({enc, enc}), .prox_i(4'h0), .enc_line_ok_i(line_ok),
		.enc_pwr_ok_i(pwr_ok), .sincos_ok_i(sc_ok), .threshold_select_bit0_i(sel[0]),
		.threshold_select_bit1_i(sel[1]), .threshold_select_bit2_i(sel[2]), .speed_ok_o(ok),
		.dir_o(dir), .fault_o(flt));

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic stop_test;
		$display("Mismatches %0d, checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		for (n = 0; n < 20 && wb_ack !== 1'b1; n++)
			@(posedge clk_i);
		if (wb_ack !== 1'b1)
		begin
			$display("ERROR wb_ack expected 1 seen %b", wb_ack);
			err_total++;
			stop_test();
		end
		else
		begin
			rd_q = wb_rdat;
			wb_cyc <= 1'b0;
			wb_we <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, exp, rd_q);
	endtask

	task automatic gates(input int n);
		repeat (n * GATE + SETTLE) @(posedge clk_i);
	endtask

	initial
	begin
		err_total = 0;
		check_count = 0;
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		sel = 3'h0;
		line_ok = 2'b11;
		pwr_ok = 2'b11;
		sc_ok = 2'b11;
		run = 1'b0;
		ccw = 1'b0;
		step = 8'h14;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_CTRL, 32'h0, "ctrl");
		rd(A_RES1, 32'h1, "res1");
		rd(A_GEARHY, 32'h1, "gearhy");
		rd(A_THR0 + 8'h1C, 32'hFFFF, "thr7");
		rd(A_UPPER, 32'hFFFF_FFFF, "upper");
		wb(1'b1, 8'h40, 32'h1234_5678);
		rd(8'h40, 32'h0, "unmapped");
		rd(A_THR0, 32'hFFFF, "thr0");
		chk("speed_ok", 1, ok);
		wb(1'b1, A_CTRL, 32'h0001_D800);
		wb(1'b1, A_RES1, 32'h258);
		wb(1'b1, A_PITCH, 32'hA);
		wb(1'b1, A_GEARHY, 32'h1401);
		for (int i = 0; i < 8; i++)
			wb(1'b1, A_THR0 + 8'(4 * i), 32'(10 * (i + 1)));
		for (int i = 0; i < 8; i++)
		begin
			sel <= 3'(i);
			gates(3);
			rd(A_UPPER, 32'(10 * (i + 1) * 600 * 100 / 60000), "upper");
			rd(A_LOWER, 32'(10 * (i + 1) * (100 - 20) / 100), "lower");
		end
		sel <= 3'h0;
		run <= 1'b1;
		step <= 8'h04;
		gates(3);
		chk("speed_ok", 0, ok);
		chk("dir", 0, dir);
		ccw <= 1'b1;
		gates(2);
		chk("speed_ok", 0, ok);
		chk("dir", 1, dir);
		step <= 8'h0B;
		gates(2);
		chk("speed_ok", 0, ok);
		step <= 8'h14;
		gates(2);
		chk("speed_ok", 1, ok);
		step <= 8'h0B;
		gates(2);
		chk("speed_ok", 1, ok);
		wb(1'b1, A_CTRL, 32'h0001_DA00);
		step <= 8'h04;
		gates(2);
		chk("speed_ok", 1, ok);
		ccw <= 1'b0;
		gates(2);
		chk("speed_ok", 0, ok);
		line_ok <= 2'b10;
		gates(1);
		chk("fault", 1, flt);
		line_ok <= 2'b11;
		pwr_ok <= 2'b10;
		gates(1);
		chk("fault", 1, flt);
		pwr_ok <= 2'b11;
		gates(2);
		chk("fault", 0, flt);
		sc_ok <= 2'b10;
		gates(1);
		chk("fault", 1, flt);
		wb(1'b1, A_CTRL, 32'h0001_FA00);
		gates(1);
		chk("fault", 0, flt);
		wb(1'b1, A_CTRL, 32'h0001_CA00);
		gates(1);
		chk("fault", 0, flt);
		sc_ok <= 2'b11;
		wb(1'b1, A_CTRL, 32'h0001_D801);
		gates(2);
		rd(A_UPPER, 32'(10 * 1000 * 600 * 100 / (60 * 10) / 1000), "upper");
		wb(1'b1, A_CTRL, 32'h0001_D803);
		gates(2);
		rd(A_UPPER, 32'(10 * 1000 * 100 / 600 / 1000), "upper");
		wb(1'b1, A_CTRL, 32'h0001_D802);
		gates(2);
		rd(A_UPPER, 32'(10 * 600 * 100 / 60000), "upper");
		stop_test();
	end
endmodule
